/* File: hw/sfi_pkg.sv */
// Constants for the serial flash instruction front end
package sfi_pkg;
  // Opcodes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_WREN_VOL  = 8'h50;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_RDSR_LO   = 8'h05;
  localparam logic [7:0] OP_RDSR_HI   = 8'h35;
  localparam logic [7:0] OP_WRSR      = 8'h01;
  localparam logic [7:0] OP_PP        = 8'h02;
  localparam logic [7:0] OP_QPP       = 8'h32;
  localparam logic [7:0] OP_SE4K      = 8'h20;
  localparam logic [7:0] OP_BE32K     = 8'h52;
  localparam logic [7:0] OP_BE64K     = 8'hd8;
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7a;
  localparam logic [7:0] OP_CRM_RESET = 8'hff;
  localparam logic [7:0] OP_ID_AB     = 8'hab;
  localparam logic [7:0] OP_ID_90     = 8'h90;
  localparam logic [7:0] OP_ID_92     = 8'h92;
  localparam logic [7:0] OP_ID_94     = 8'h94;
  localparam logic [7:0] OP_ID_9F     = 8'h9f;
  // Identity values, arbitrary
  localparam logic [7:0]  MAKER_CODE_VAL = 8'h5a;
  localparam logic [7:0]  PART_CODE_VAL  = 8'h3c;
  localparam logic [15:0] PART_CODE16    = 16'h3c3c;
  // Array geometry
  localparam logic [23:0] ARRAY_TOP  = 24'h0fffff;
  localparam logic [23:0] SZ_4K      = 24'h000fff;
  localparam logic [23:0] SZ_32K     = 24'h007fff;
  localparam logic [23:0] SZ_64K     = 24'h00ffff;
  localparam logic [23:0] SZ_PAGE    = 24'h0000ff;
  // Command kinds handed to the array engine
  localparam logic [2:0] KIND_PROG  = 3'h0;
  localparam logic [2:0] KIND_SE    = 3'h1;
  localparam logic [2:0] KIND_BE32  = 3'h2;
  localparam logic [2:0] KIND_BE64  = 3'h3;
  localparam logic [2:0] KIND_WRSR  = 3'h4;
  localparam int BYTE_BITS = 8;
  // Frame states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_STAT = 3'b100,
    ST_ID   = 3'b101,
    ST_SKIP = 3'b110
  } sfi_state_t;
endpackage : sfi_pkg

/* File: hw/sfi_prot_check.sv */
// Complement protect region check for erase and program targets
`timescale 1ns/1ps
module sfi_prot_check
  import sfi_pkg::*;
(
  input  wire logic        complement_protect_i,
  input  wire logic        sector_granularity_select_i,
  input  wire logic        top_bottom_select_i,
  input  wire logic [2:0]  block_protect_i,
  input  wire logic [23:0] span_lo_i,
  input  wire logic [23:0] span_hi_i,
  output logic             blocked_o
);
  logic        any_prot;
  logic [23:0] prot_lo;
  logic [23:0] prot_hi;

  // Protected range lookup; only complement mode is mapped
  always_comb
  begin
    any_prot = 1'b0;
    prot_lo  = 24'h000000;
    prot_hi  = ARRAY_TOP;
    if (complement_protect_i)
    begin
      if (block_protect_i == 3'b000)
        any_prot = 1'b1;
      else if (!sector_granularity_select_i)
      begin
        any_prot = (block_protect_i <= 3'b100);
        unique case (block_protect_i)
          3'b001:  prot_hi = 24'h0effff;
          3'b010:  prot_hi = 24'h0dffff;
          3'b011:  prot_hi = 24'h0bffff;
          default: prot_hi = 24'h07ffff;
        endcase
        if (top_bottom_select_i)
        begin
          prot_hi = ARRAY_TOP;
          unique case (block_protect_i)
            3'b001:  prot_lo = 24'h010000;
            3'b010:  prot_lo = 24'h020000;
            3'b011:  prot_lo = 24'h040000;
            default: prot_lo = 24'h080000;
          endcase
        end
      end
      else
      begin
        any_prot = (block_protect_i != 3'b111);
        unique case (block_protect_i)
          3'b001:  prot_hi = 24'h0fefff;
          3'b010:  prot_hi = 24'h0fdfff;
          3'b011:  prot_hi = 24'h0fbfff;
          default: prot_hi = 24'h0f7fff;
        endcase
        if (top_bottom_select_i)
        begin
          prot_hi = ARRAY_TOP;
          unique case (block_protect_i)
            3'b001:  prot_lo = 24'h001000;
            3'b010:  prot_lo = 24'h002000;
            3'b011:  prot_lo = 24'h004000;
            default: prot_lo = 24'h008000;
          endcase
        end
      end
    end
  end

  // Whole span overlap, not only the start address
  assign blocked_o = any_prot && (span_lo_i <= prot_hi) && (span_hi_i >= prot_lo);
endmodule : sfi_prot_check

/* File: hw/sfi_frontend.sv */
// Serial flash instruction front end: framing, decode, guards
// What this block does
// - Complement set, block-protect zero: the whole array is protected.
// - Complement, 64KB, bottom: codes 1..4 protect from zero to listed tops.
// - Complement, 64KB, top: codes 1..4 protect from listed bases to array top.
// - Complement, 4KB, bottom: protect from zero, leaving a small top writable.
// - Complement, 4KB, top: protect from listed base up to array top.
// - Erase or program touching a protected address is dropped.
// - Chip select falling starts a frame; first byte is the opcode.
// - Serial input sampled on clock rise, most significant bit first.
// - Chip select rising ends the current instruction.
// - Reads may end after any bit count without side effect.
// - Writes, serial programs, erases act only on whole-byte endings.
// - While busy only status reads are honoured.
// - 06h sets write enable, 50h volatile enable, 04h clears write enable only.
// - 05h and 35h return status bytes repeatedly until deselect.
// - Status write: 01h, then low byte, then high byte.
// - Program and erases carry three address bytes, most significant first.
// - Quad program data: four bits per clock, high nibble first.
// - 75h suspends and 7Ah resumes; both single byte.
// - ID opcodes return maker and part codes.
// - Complement clear leaves the whole array unprotected.
// - Quad lines 2 and 3 work only when quad enable is set.
// - Write enable latch must be set before programs and erases; status writes also take volatile enable.
`timescale 1ns/1ps
module sfi_frontend
  import sfi_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        serial_in_i,
  input  wire logic [3:0]  quad_line_i,
  input  wire logic [15:0] status_i,
  input  wire logic        busy_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  output logic             write_enable_latch_o,
  output logic             vol_write_enable_o,
  output logic             cmd_valid_o,
  output logic [2:0]       cmd_kind_o,
  output logic [23:0]      cmd_addr_o,
  output logic [15:0]      wrsr_value_o,
  output logic             data_valid_o,
  output logic [7:0]       data_byte_o,
  output logic             suspend_o,
  output logic             resume_o
);
  import sfi_pkg::*;

  // Two-stage synchronisers for link pins
  logic [1:0] cs_sync, ck_sync, di_sync;
  logic [3:0] q_s1, q_s2;
  logic       ck_prev, cs_prev;
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_sync <= 2'b11;
      ck_sync <= 2'b00;
      di_sync <= 2'b00;
      q_s1    <= 4'h0;
      q_s2    <= 4'h0;
      ck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      cs_sync <= {cs_sync[0], cs_n_i};
      ck_sync <= {ck_sync[0], sclk_i};
      di_sync <= {di_sync[0], serial_in_i};
      q_s1    <= quad_line_i;
      q_s2    <= q_s1;
      ck_prev <= ck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  wire cs_n    = cs_sync[1];
  wire ck_rise = !cs_n && ck_sync[1] && !ck_prev;
  wire ck_fall = !cs_n && !ck_sync[1] && ck_prev;
  wire cs_fall = cs_prev && !cs_n;
  wire cs_rise = !cs_prev && cs_n;
  // Quad lines 2 and 3 only honoured with quad enable (status bit 9)
  wire quad_en = status_i[9];

  sfi_state_t  state;
  logic [7:0]  shreg;
  logic [2:0]  bitcnt;
  logic [1:0]  addr_cnt;
  logic [7:0]  opcode;
  logic [23:0] addr;
  logic [15:0] wrsr_buf;
  logic [1:0]  wrsr_cnt;
  logic        nib_hi;
  logic [3:0]  nib_buf;
  logic [7:0]  out_sh;
  logic [2:0]  out_cnt;
  logic [1:0]  id_idx;
  logic        page_seen;

  // Bit collection, MSB first
  wire [7:0] next_byte = {shreg[6:0], di_sync[1]};
  wire       byte_done = ck_rise && (bitcnt == 3'h7);
  wire       whole     = (bitcnt == 3'h0);

  // Opcode classes
  wire is_addr_op = (next_byte == OP_PP) || (next_byte == OP_QPP) || (next_byte == OP_SE4K)
                 || (next_byte == OP_BE32K) || (next_byte == OP_BE64K);
  wire is_stat_op = (next_byte == OP_RDSR_LO) || (next_byte == OP_RDSR_HI);
  wire is_id_op   = (next_byte == OP_ID_AB) || (next_byte == OP_ID_90)
                 || (next_byte == OP_ID_92) || (next_byte == OP_ID_94)
                 || (next_byte == OP_ID_9F);
  wire is_quad    = (opcode == OP_QPP);
  wire [2:0] kind = (opcode == OP_SE4K)  ? KIND_SE :
                    (opcode == OP_BE32K) ? KIND_BE32 :
                    (opcode == OP_BE64K) ? KIND_BE64 : KIND_PROG;

  // Target span aligned per erase size
  wire [23:0] span_mask = (kind == KIND_SE)   ? SZ_4K :
                          (kind == KIND_BE32) ? SZ_32K :
                          (kind == KIND_BE64) ? SZ_64K : SZ_PAGE;
  wire [23:0] span_lo   = addr & ~span_mask;
  wire [23:0] span_hi   = addr | span_mask;
  logic blocked;
  sfi_prot_check u_prot (
    .complement_protect_i       (status_i[14]),
    .sector_granularity_select_i(status_i[6]),
    .top_bottom_select_i        (status_i[5]),
    .block_protect_i            (status_i[4:2]),
    .span_lo_i                  (span_lo),
    .span_hi_i                  (span_hi),
    .blocked_o                  (blocked)
  );

  // Ending checks applied at chip select rise
  wire end_ok  = whole && write_enable_latch_o && !busy_i;
  wire do_erase = cs_rise && (state == ST_ADDR) && (addr_cnt == 2'h3) && end_ok
               && (kind != KIND_PROG) && !blocked;
  wire do_prog  = cs_rise && (state == ST_DATA) && page_seen && end_ok && !blocked;
  wire do_wrsr  = cs_rise && (opcode == OP_WRSR) && (wrsr_cnt != 2'h0) && whole && !busy_i
               && (write_enable_latch_o || vol_write_enable_o);
  // Single-byte instructions also need a clean byte ending
  wire single   = cs_rise && (state == ST_SKIP) && whole && !busy_i && (addr_cnt == 2'h0);

  // Quad nibble assembly: lines 2,3 forced low without quad enable
  wire [3:0] qin   = {quad_en ? q_s2[3:2] : 2'b00, q_s2[1:0]};
  wire [7:0] qbyte = {nib_buf, qin};

  // Frame state machine
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state    <= ST_IDLE;
      shreg    <= 8'h00;
      bitcnt   <= 3'h0;
      addr_cnt <= 2'h0;
      opcode   <= 8'h00;
      addr     <= 24'h000000;
      wrsr_cnt <= 2'h0;
      wrsr_buf <= 16'h0000;
      nib_hi   <= 1'b1;
      nib_buf  <= 4'h0;
      page_seen <= 1'b0;
    end
    else if (cs_n)
      state <= ST_IDLE;
    else if (cs_fall)
    begin
      state    <= ST_OPC;
      bitcnt   <= 3'h0;
      addr_cnt <= 2'h0;
      wrsr_cnt <= 2'h0;
      nib_hi   <= 1'b1;
      page_seen <= 1'b0;
      opcode   <= 8'h00;
    end
    else if (ck_rise)
    begin
      shreg  <= next_byte;
      bitcnt <= bitcnt + 3'h1;
      if (state == ST_DATA && is_quad)
      begin
        bitcnt <= 3'h0;                                           // Quad: bit count held at zero, so every nibble ends on a boundary
        nib_hi <= !nib_hi;
        if (nib_hi) nib_buf <= qin;
        else page_seen <= 1'b1;
      end
      else if (byte_done)
      begin
        unique case (state)
          ST_OPC:
          begin
            opcode <= next_byte;
            if (busy_i && !is_stat_op)
              state <= ST_SKIP;
            else if (is_stat_op)
              state <= ST_STAT;
            else if (is_id_op)
              state <= ST_ID;
            else if (is_addr_op)
              state <= ST_ADDR;
            else if (next_byte == OP_WRSR)
              state <= ST_DATA;
            else
              state <= ST_SKIP;
          end
          ST_ADDR:
          begin
            addr     <= {addr[15:0], next_byte};
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == 2'h2 && opcode != OP_SE4K && opcode != OP_BE32K
                && opcode != OP_BE64K)
              state <= ST_DATA;
          end
          ST_DATA:
          begin
            page_seen <= 1'b1;
            if (opcode == OP_WRSR && wrsr_cnt != 2'h2)
            begin
              wrsr_buf <= (wrsr_cnt == 2'h0) ? {wrsr_buf[15:8], next_byte}
                                             : {next_byte, wrsr_buf[7:0]};
              wrsr_cnt <= wrsr_cnt + 2'h1;
            end
          end
          ST_SKIP:  addr_cnt <= 2'h1;                             // Extra byte voids single-byte ops
          default:  state <= state;
        endcase
      end
    end
  end

  // Output shifter for status and identity, changes on clock fall
  wire [7:0] id_byte = (opcode == OP_ID_9F) ? ((id_idx == 2'h0) ? MAKER_CODE_VAL :
                       (id_idx == 2'h1) ? PART_CODE16[15:8] : PART_CODE16[7:0]) :
                       (id_idx[0] ? PART_CODE_VAL : MAKER_CODE_VAL);
  wire [7:0] stat_byte = (opcode == OP_RDSR_HI) ? status_i[15:8] : status_i[7:0];
  wire       load_out  = (byte_done && state == ST_OPC && (is_stat_op || is_id_op));
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_sh  <= 8'h00;
      out_cnt <= 3'h0;
      id_idx  <= 2'h0;
      serial_out_oe_o <= 1'b0;
      serial_out_o    <= 1'b0;
    end
    else if (cs_n)
    begin
      serial_out_oe_o <= 1'b0;
      out_cnt <= 3'h0;
      id_idx  <= 2'h0;
    end
    else if (load_out)
    begin
      out_sh  <= is_stat_op ? ((next_byte == OP_RDSR_HI) ? status_i[15:8] : status_i[7:0])
                            : MAKER_CODE_VAL;
      out_cnt <= 3'h0;
      id_idx  <= 2'h1;                                            // Maker code already loaded
    end
    else if (ck_fall && (state == ST_STAT || state == ST_ID))
    begin
      serial_out_oe_o <= 1'b1;
      serial_out_o    <= out_sh[7];
      out_sh  <= {out_sh[6:0], 1'b0};
      out_cnt <= out_cnt + 3'h1;
      if (out_cnt == 3'h7)
      begin
        // Repeat status byte; identity walks its code list
        out_sh <= (state == ST_STAT) ? stat_byte : id_byte;
        id_idx <= (opcode != OP_ID_9F) ? {1'b0, ~id_idx[0]}
                : (id_idx == 2'h2) ? 2'h0 : id_idx + 2'h1;
      end
    end
  end

  // Command outputs and latches
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      write_enable_latch_o <= 1'b0;
      vol_write_enable_o   <= 1'b0;
      cmd_valid_o  <= 1'b0;
      cmd_kind_o   <= KIND_PROG;
      cmd_addr_o   <= 24'h000000;
      wrsr_value_o <= 16'h0000;
      data_valid_o <= 1'b0;
      data_byte_o  <= 8'h00;
      suspend_o    <= 1'b0;
      resume_o     <= 1'b0;
    end
    else
    begin
      cmd_valid_o  <= 1'b0;
      data_valid_o <= 1'b0;
      suspend_o    <= 1'b0;
      resume_o     <= 1'b0;
      // Stream page data bytes as they arrive
      if (state == ST_DATA && opcode != OP_WRSR && ck_rise && !busy_i)
      begin
        if (is_quad && !nib_hi)
        begin
          data_valid_o <= 1'b1;
          data_byte_o  <= qbyte;
        end
        else if (!is_quad && byte_done)
        begin
          data_valid_o <= 1'b1;
          data_byte_o  <= next_byte;
        end
      end
      if (single)
      begin
        unique case (opcode)
          OP_WREN:     write_enable_latch_o <= 1'b1;
          OP_WREN_VOL: vol_write_enable_o   <= 1'b1;
          OP_WRDI:     write_enable_latch_o <= 1'b0;
          OP_SUSPEND:  suspend_o <= 1'b1;
          OP_RESUME:   resume_o  <= 1'b1;
          default:     write_enable_latch_o <= write_enable_latch_o;
        endcase
      end
      if (do_erase || do_prog || do_wrsr)
      begin
        cmd_valid_o  <= 1'b1;
        cmd_kind_o   <= do_wrsr ? KIND_WRSR : kind;
        cmd_addr_o   <= addr;
        wrsr_value_o <= wrsr_buf;
        write_enable_latch_o <= 1'b0;
        vol_write_enable_o   <= 1'b0;
      end
    end
  end
endmodule : sfi_frontend

/* File: sim/sfi_host_model.sv */
// SPI host model that frames instructions on the front end's link pins
`timescale 1ns/1ps
module sfi_host_model
(
  input  wire logic       ref_clk_i,
  input  wire logic       serial_out_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic            serial_in_o,
  output logic [3:0]      quad_line_o
);
  logic [15:0] rx;
  // Idle: deselected, link clock parked low
  initial
  begin
    cs_n_o      = 1'b1;
    sclk_o      = 1'b0;
    serial_in_o = 1'b0;
    quad_line_o = 4'h0;
    rx          = 16'h0;
  end
  // One link clock, 4 ref cycles low then 4 high; sample just before the fall
  task automatic clk_bit(input logic d, input logic [3:0] q);
    serial_in_o = d;
    quad_line_o = q;
    repeat (4) @(negedge ref_clk_i);
    sclk_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    rx     = {rx[14:0], serial_out_i};
    sclk_o = 1'b0;
  endtask : clk_bit
  // Top n bits of v, most significant first
  task automatic bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
      clk_bit(v[i], quad_line_o);
  endtask : bits
  // Quad data, one nibble a clock
  task automatic nib(input logic [3:0] q);
    clk_bit(~serial_in_o, q);
  endtask : nib
  // Chip select falls to open a frame
  task automatic start();
    @(negedge ref_clk_i);
    cs_n_o = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask : start
  // Chip select rises; released lines stop showing the last value
  task automatic stop();
    repeat (3) @(negedge ref_clk_i);
    cs_n_o      = 1'b1;
    serial_in_o = ~serial_in_o;
    quad_line_o = ~quad_line_o;
    repeat (8) @(negedge ref_clk_i);
  endtask : stop
endmodule : sfi_host_model

/* File: sim/sfi_frontend_chk.sv */
// Concurrent checks on the front end's ports
`timescale 1ns/1ps
module sfi_frontend_chk
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cs_n_i,
  input  wire logic [15:0] status_i,
  input  wire logic        busy_i,
  input  wire logic        serial_out_oe_o,
  input  wire logic        write_enable_latch_o,
  input  wire logic        cmd_valid_o,
  input  wire logic [2:0]  cmd_kind_o,
  input  wire logic [23:0] cmd_addr_o,
  input  wire logic        suspend_o,
  input  wire logic        resume_o
);
  import sfi_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Array commands only; status writes skip the protection map
  wire logic ers = cmd_valid_o && (cmd_kind_o != KIND_WRSR);
  wire logic cmp = status_i[14];
  wire logic act = cmd_valid_o || suspend_o || resume_o;

  act_at_end_a: assert property (cmd_valid_o |-> cs_n_i && $past(cs_n_i, 2))
    else $error("command issued before deselect");
  one_pulse_a: assert property (act |=> !act)
    else $error("action pulse longer than one cycle");
  latch_needed_a: assert property (ers |-> $past(write_enable_latch_o))
    else $error("array command without write enable");
  busy_refuse_a: assert property (cmd_valid_o |-> !busy_i)
    else $error("command issued while busy");
  all_prot_a: assert property (ers |-> !(cmp && status_i[4:2] == 3'h0))
    else $error("command into fully protected array");
  bottom_half_a: assert property (ers && cmp && status_i[6:2] == 5'h04 |-> cmd_addr_o > 24'h07ffff)
    else $error("command into protected lower half");
  top_half_a: assert property (ers && cmp && status_i[6:2] == 5'h0c |-> cmd_addr_o < 24'h080000)
    else $error("command into protected upper half");
  small_top_a: assert property (ers && cmp && status_i[6:2] == 5'h14 |-> cmd_addr_o > 24'h0f7fff)
    else $error("command below writable top region");
  oe_in_frame_a: assert property ($rose(serial_out_oe_o) |-> !cs_n_i)
    else $error("output driven outside a frame");
  latch_rise_a: assert property ($rose(write_enable_latch_o) |-> cs_n_i && !busy_i)
    else $error("latch set mid frame or while busy");
endmodule : sfi_frontend_chk

bind sfi_frontend sfi_frontend_chk u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .status_i(status_i),
  .busy_i(busy_i), .serial_out_oe_o(serial_out_oe_o),
  .write_enable_latch_o(write_enable_latch_o), .cmd_valid_o(cmd_valid_o),
  .cmd_kind_o(cmd_kind_o), .cmd_addr_o(cmd_addr_o), .suspend_o(suspend_o),
  .resume_o(resume_o));

/* File: sim/testbench.sv */
// Self-checking bench for the serial flash instruction front end
`timescale 1ns/1ps
module testbench;
  import sfi_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [15:0] status_i  = 16'h0;
  logic        busy_i    = 1'b0;
  logic        cs_n, sclk, sdi, sdo, oe, write_enable_latch, vol, cv, dv, sus, res;
  logic [3:0]  quad;
  logic [2:0]  kind, last_kind;
  logic [23:0] addr, last_addr;
  logic [15:0] wrv;
  logic [7:0]  dbyte, last_data;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          ncmd = 0;
  int          nsus = 0;
  int          nres = 0;
  int          cyc  = 0;
  int          n0;
  // Protection boundaries: bottom tops, then top bases, per granularity
  logic [23:0] bnd [16] = '{24'h0effff, 24'h0dffff, 24'h0bffff, 24'h07ffff,
                           24'h010000, 24'h020000, 24'h040000, 24'h080000,
                           24'h0fefff, 24'h0fdfff, 24'h0fbfff, 24'h0f7fff,
                           24'h001000, 24'h002000, 24'h004000, 24'h008000};
  logic [7:0]  eop [3] = '{OP_SE4K, OP_BE32K, OP_BE64K};

  always #5 ref_clk_i = ~ref_clk_i;

  sfi_host_model host (.ref_clk_i(ref_clk_i), .serial_out_i(sdo), .cs_n_o(cs_n),
    .sclk_o(sclk), .serial_in_o(sdi), .quad_line_o(quad));
  sfi_frontend DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .serial_in_i(sdi), .quad_line_i(quad), .status_i(status_i), .busy_i(busy_i),
    .serial_out_o(sdo), .serial_out_oe_o(oe), .write_enable_latch_o(write_enable_latch),
    .vol_write_enable_o(vol), .cmd_valid_o(cv), .cmd_kind_o(kind), .cmd_addr_o(addr),
    .wrsr_value_o(wrv), .data_valid_o(dv), .data_byte_o(dbyte), .suspend_o(sus),
    .resume_o(res));

  // Tally action pulses and keep what they carried; cut a hang short
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cv === 1'b1)
    begin
      ncmd      <= ncmd + 1;
      last_kind <= kind;
      last_addr <= addr;
    end
    if (dv === 1'b1)
      last_data <= dbyte;
    if (sus === 1'b1)
      nsus <= nsus + 1;
    if (res === 1'b1)
      nres <= nres + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // Opcode, na address bytes, then nx trailing bits of x
  task automatic frame(input logic [7:0] op, input int na, input logic [23:0] a,
                       input logic [7:0] x, input int nx);
    host.start();
    host.bits(op, 8);
    for (int k = 0; k < na; k++)
      host.bits(a[23 - 8 * k -: 8], 8);
    host.bits(x, nx);
    host.stop();
  endtask : frame

  // Write enable, then an array command; ok says whether it must issue
  task automatic erase(input logic [7:0] op, input logic [23:0] a, input logic ok);
    n0 = ncmd;
    frame(OP_WREN, 0, 24'h0, 8'h0, 0);
    frame(op, 3, a, 8'h0, 0);
    chk("command count", 24'(n0 + int'(ok)), 24'(ncmd));
    if (ok)
      chk("command address", a, last_addr);
  endtask : erase

  task automatic setp(input logic c, input logic s, input logic t, input logic [2:0] b,
                      input logic q);
    status_i = {1'b0, c, 4'h0, q, 2'h0, s, t, b, 2'h0};
  endtask : setp

  initial
  begin
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("outputs after reset", 24'h0, {18'h0, write_enable_latch, vol, cv, oe, sus, res});
    frame(OP_WREN, 0, 24'h0, 8'h0, 0);
    chk("write enable latch", 24'h1, {23'h0, write_enable_latch});
    frame(OP_WRDI, 0, 24'h0, 8'h0, 0);
    chk("write enable latch", 24'h0, {23'h0, write_enable_latch});
    n0 = ncmd;
    frame(OP_SE4K, 3, 24'h0, 8'h0, 0);
    chk("command without latch", 24'(n0), 24'(ncmd));
    host.start();
    host.bits(OP_RDSR_LO, 8);
    host.bits(8'h0, 3);
    host.stop();
    chk("count after cut read", 24'(n0), 24'(ncmd));
    frame(OP_WREN_VOL, 0, 24'h0, 8'h0, 0);
    chk("volatile enable", 24'h1, {23'h0, vol});
    frame(OP_WRSR, 2, 24'h123400, 8'h0, 0);
    chk("status write value", 24'h003412, {8'h0, wrv});
    chk("status write kind", 24'(KIND_WRSR), {21'h0, last_kind});
    for (int k = 0; k < 3; k++)
    begin
      erase(eop[k], 24'h012000, 1'b1);
      chk("erase kind", 24'(k + 1), {21'h0, last_kind});
    end
    frame(OP_WREN, 0, 24'h0, 8'h0, 0);
    frame(OP_PP, 3, 24'h034500, 8'ha5, 8);
    chk("program data", 24'h0000a5, {16'h0, last_data});
    chk("program kind", 24'(KIND_PROG), {21'h0, last_kind});
    for (int q = 0; q < 2; q++)
    begin
      setp(1'b0, 1'b0, 1'b0, 3'h0, q[0]);
      frame(OP_WREN, 0, 24'h0, 8'h0, 0);
      host.start();
      host.bits(OP_QPP, 8);
      repeat (3) host.bits(8'h00, 8);
      host.nib(4'hc);
      host.nib(4'h3);
      host.stop();
      chk("quad data", q ? 24'h0000c3 : 24'h000003, {16'h0, last_data});
    end
    n0 = ncmd;
    frame(OP_WREN, 0, 24'h0, 8'h0, 0);
    frame(OP_SE4K, 3, 24'h0, 8'hff, 3);
    chk("count after ragged end", 24'(n0), 24'(ncmd));
    frame(OP_CRM_RESET, 1, 24'hff0000, 8'h0, 0);
    frame(OP_WRDI, 0, 24'h0, 8'h0, 0);
    status_i = 16'ha5c3;
    busy_i   = 1'b1;
    host.start();
    host.bits(OP_RDSR_LO, 8);
    host.bits(8'h0, 8);
    host.bits(8'h0, 8);
    chk("status low repeated", 24'h00c3c3, {8'h0, host.rx});
    chk("output enable", 24'h1, {23'h0, oe});
    host.stop();
    host.start();
    host.bits(OP_RDSR_HI, 8);
    host.bits(8'h0, 8);
    chk("status high", 24'h0000a5, {16'h0, host.rx[7:0]});
    host.stop();
    chk("output released", 24'h0, {23'h0, oe});
    frame(OP_WREN, 0, 24'h0, 8'h0, 0);
    chk("latch while busy", 24'h0, {23'h0, write_enable_latch});
    busy_i = 1'b0;
    frame(OP_SUSPEND, 0, 24'h0, 8'h0, 0);
    chk("suspend count", 24'h1, 24'(nsus));
    frame(OP_RESUME, 0, 24'h0, 8'h0, 0);
    chk("resume count", 24'h1, 24'(nres));
    frame(OP_SUSPEND, 1, 24'h0, 8'h0, 0);
    chk("suspend with extra byte", 24'h1, 24'(nsus));
    host.start();
    host.bits(OP_ID_9F, 8);
    repeat (2) host.bits(8'h0, 8);
    chk("identity first bytes", {8'h0, MAKER_CODE_VAL, PART_CODE16[15:8]}, {8'h0, host.rx});
    host.bits(8'h0, 8);
    chk("identity last bytes", {8'h0, PART_CODE16}, {8'h0, host.rx});
    host.stop();
    host.start();
    host.bits(OP_ID_90, 8);
    repeat (2) host.bits(8'h0, 8);
    chk("maker and part", {8'h0, MAKER_CODE_VAL, PART_CODE_VAL}, {8'h0, host.rx});
    host.stop();
    setp(1'b1, 1'b0, 1'b0, 3'h0, 1'b0);
    erase(OP_SE4K, 24'h0f0000, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      setp(1'b1, i[3], i[2], 3'(i % 4 + 1), 1'b0);
      if (!i[2])
      begin
        erase(OP_SE4K, {bnd[i][23:12], 12'h000}, 1'b0);
        erase(OP_SE4K, bnd[i] + 24'h1, 1'b1);
      end
      else
      begin
        erase(OP_SE4K, bnd[i] - 24'h001000, 1'b1);
        erase(OP_SE4K, bnd[i], 1'b0);
      end
    end
    for (int j = 5; j < 9; j++)
    begin
      setp(1'b1, j == 8, 1'b0, (j == 8) ? 3'h7 : 3'(j), 1'b0);
      erase(OP_SE4K, 24'h0, 1'b1);
    end
    setp(1'b1, 1'b1, 1'b1, 3'h4, 1'b0);
    erase(OP_BE32K, 24'h0, 1'b1);
    erase(OP_BE64K, 24'h0, 1'b0);
    results();
  end
endmodule : testbench
